// ### rtl/alert_reply_acceptor.sv
// node-side acceptor for alert reply messages and the pending-alert queue
`default_nettype none
module alert_reply_acceptor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // incoming management message bytes
  input wire logic i_msg_valid,
  input wire logic i_msg_first,
  input wire logic i_msg_last,
  input wire logic [7:0] i_msg_byte,
  // alert enqueue from the alert generator
  input wire logic i_alert_push,
  input wire logic [7:0] i_alert_type,
  input wire logic [7:0] i_alert_subclass,
  input wire logic [7:0] i_alert_info,
  // tag assignment from port setup message
  input wire logic i_tag_load,
  input wire logic [15:0] i_tag_value,
  // results
  output logic o_accept,
  output logic o_discard,
  output logic o_dequeue_start,
  output logic [7:0] o_return_code,
  output logic o_push_refused,
  output logic o_privileged,
  output logic o_pending,
  output logic o_queue_full,
  output logic [15:0] o_alert_tag
);
  localparam int PW = alert_reply_pkg::PTR_W;
  localparam int DEPTH = alert_reply_pkg::QUEUE_DEPTH;

  alert_reply_pkg::parse_state_t state, next_state;
  logic [2:0] byte_idx;
  logic [7:0] rx_rc, rx_type, rx_sub, rx_info;
  logic [15:0] rx_tag;
  logic hdr_ok;
  logic [23:0] q_code [DEPTH];
  logic [PW-1:0] rd_ptr, wr_ptr;
  logic [PW:0] count;
  logic push_link_err, push_master;
  logic push_ok, pop;
  logic [23:0] head_code;
  logic match;

  // range checks on the type of an alert being queued
  alert_code_classifier u_class (
    .i_type(i_alert_type),
    .o_link_error(push_link_err),
    .o_master_only(push_master)
  );

  // master-only types and a full queue are refused at the push
  assign push_ok = i_alert_push && !push_master &&
                   (count != DEPTH[PW:0]);
  assign head_code = q_code[rd_ptr];
  // only the head entry is compared; tag is the active port tag
  assign match = (count != '0) && hdr_ok &&
                 (rx_tag == o_alert_tag) &&
                 ({rx_type, rx_sub, rx_info} == head_code);
  assign pop = (state == alert_reply_pkg::ST_CHECK) && match;

  // byte parser state
  always_comb begin
    next_state = state;
    case (state)
      alert_reply_pkg::ST_IDLE: begin
        if (i_msg_valid && i_msg_first) begin
          if (i_msg_byte != alert_reply_pkg::REPLY_CODE) begin
            next_state = i_msg_last ? alert_reply_pkg::ST_IDLE
                                    : alert_reply_pkg::ST_DROP;
          end else if (!i_msg_last) begin
            next_state = alert_reply_pkg::ST_BODY;
          end
        end
      end
      alert_reply_pkg::ST_BODY: begin
        if (i_msg_valid && i_msg_last) begin
          next_state = alert_reply_pkg::ST_CHECK;
        end
      end
      alert_reply_pkg::ST_DROP: begin
        if (i_msg_valid && i_msg_last) begin
          next_state = alert_reply_pkg::ST_IDLE;
        end
      end
      alert_reply_pkg::ST_CHECK: next_state = alert_reply_pkg::ST_IDLE;
      default: next_state = alert_reply_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= alert_reply_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // byte index and field capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      byte_idx <= 3'h0;
      rx_rc <= 8'h00;
      rx_tag <= 16'h0000;
      rx_type <= 8'h00;
      rx_sub <= 8'h00;
      rx_info <= 8'h00;
      hdr_ok <= 1'b0;
    end else if (i_msg_valid) begin
      if (i_msg_first) begin
        byte_idx <= 3'h1;
        hdr_ok <= 1'b0;
      end else if (state == alert_reply_pkg::ST_BODY) begin
        if (byte_idx != alert_reply_pkg::BYTE_INFO + 3'h1) begin
          byte_idx <= byte_idx + 3'h1;
        end
        case (byte_idx)
          alert_reply_pkg::BYTE_RC: rx_rc <= i_msg_byte;
          alert_reply_pkg::BYTE_TAG_HI: rx_tag[15:8] <= i_msg_byte;
          alert_reply_pkg::BYTE_TAG_LO: rx_tag[7:0] <= i_msg_byte;
          alert_reply_pkg::BYTE_TYPE: rx_type <= i_msg_byte;
          alert_reply_pkg::BYTE_SUBCLASS: rx_sub <= i_msg_byte;
          alert_reply_pkg::BYTE_INFO: begin
            rx_info <= i_msg_byte;
            hdr_ok <= 1'b1; // short replies never match
          end
          default: ;
        endcase
      end
    end
  end

  // pending-alert queue storage
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      q_code[wr_ptr] <= {i_alert_type, i_alert_subclass, i_alert_info};
    end
  end

  // queue pointers and occupancy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push_ok && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push_ok) begin
        count <= count - 1'b1;
      end
    end
  end

  // alert tag: kept across replies, changed only by port setup
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alert_tag <= 16'h0000;
    end else if (i_tag_load) begin
      o_alert_tag <= i_tag_value;
    end
  end

  // one-cycle outcome pulses and captured return code
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept <= 1'b0;
      o_discard <= 1'b0;
      o_dequeue_start <= 1'b0;
      o_return_code <= alert_reply_pkg::RC_OK;
      o_push_refused <= 1'b0;
    end else begin
      o_accept <= pop;
      o_discard <= (state == alert_reply_pkg::ST_CHECK) && !match;
      o_dequeue_start <= pop;
      if (pop) begin
        o_return_code <= rx_rc;
      end
      o_push_refused <= i_alert_push && !push_ok;
    end
  end

  // status levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_privileged <= 1'b0;
      o_pending <= 1'b0;
      o_queue_full <= 1'b0;
    end else begin
      if (push_ok && push_link_err) begin
        o_privileged <= 1'b1;
      end else if (i_tag_load) begin
        o_privileged <= 1'b0; // port setup returns port to normal
      end
      o_pending <= (count != '0);
      o_queue_full <= (count == DEPTH[PW:0]);
    end
  end
endmodule
`default_nettype wire

// ### rtl/alert_reply_pkg.sv
// constants and types for the alert reply acceptor
`default_nettype none
package alert_reply_pkg;
  localparam logic [7:0] REPLY_CODE = 8'h07;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_INVALID = 8'hff;
  localparam logic [7:0] LINK_ERR_LO = 8'h10;
  localparam logic [7:0] LINK_ERR_HI = 8'h19;
  localparam logic [7:0] MASTER_TYPE_LO = 8'hbc;
  localparam logic [2:0] BYTE_CODE = 3'h0;
  localparam logic [2:0] BYTE_RC = 3'h1;
  localparam logic [2:0] BYTE_TAG_HI = 3'h2;
  localparam logic [2:0] BYTE_TAG_LO = 3'h3;
  localparam logic [2:0] BYTE_TYPE = 3'h4;
  localparam logic [2:0] BYTE_SUBCLASS = 3'h5;
  localparam logic [2:0] BYTE_INFO = 3'h6;
  localparam int QUEUE_DEPTH = 4;
  localparam int PTR_W = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BODY = 2'b01,
    ST_DROP = 2'b10,
    ST_CHECK = 2'b11
  } parse_state_t;
endpackage
`default_nettype wire

// ### rtl/alert_code_classifier.sv
// classifies an alert type byte into link error and master-only ranges
`default_nettype none
module alert_code_classifier (
  // type byte in
  input wire logic [7:0] i_type,
  // classification out
  output logic o_link_error,
  output logic o_master_only
);
  // link errors leave the port privileged once queued; one refused by a full queue does not
  assign o_link_error = (i_type >= alert_reply_pkg::LINK_ERR_LO) &&
                        (i_type <= alert_reply_pkg::LINK_ERR_HI);
  // master-only types may not be queued by a node
  assign o_master_only = i_type >= alert_reply_pkg::MASTER_TYPE_LO;
endmodule
`default_nettype wire

// ### verif/alert_reply_monitor.sv
// assertion checker bound to the alert reply acceptor
`default_nettype none
module alert_reply_monitor (
  // watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_alert_push,
  input wire logic i_tag_load,
  input wire logic [15:0] i_tag_value,
  input wire logic o_accept,
  input wire logic o_discard,
  input wire logic o_dequeue_start,
  input wire logic o_push_refused,
  input wire logic o_privileged,
  input wire logic [15:0] o_alert_tag
);
  timeunit 1ns / 1ps;
  // one clock domain, checks off in reset
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_pair; o_accept |-> o_dequeue_start; endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_pop; o_dequeue_start |-> o_accept; endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_excl; !(o_accept && o_discard); endproperty
  a_excl: assert property (p_excl) else $error("excl");
  property p_one; o_accept |=> !o_accept; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_drop; o_discard |=> !o_discard; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_tag; i_tag_load |=> o_alert_tag == $past(i_tag_value);
  endproperty
  a_tag: assert property (p_tag) else $error("tag");
  property p_keep; !i_tag_load |=> $stable(o_alert_tag); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_why; o_push_refused |-> $past(i_alert_push); endproperty
  a_why: assert property (p_why) else $error("why");
  // privileged mode only follows a queued alert
  property p_priv; $rose(o_privileged) |-> $past(i_alert_push); endproperty
  a_priv: assert property (p_priv) else $error("priv");
endmodule
bind alert_reply_acceptor alert_reply_monitor mon (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_alert_push(i_alert_push),
  .i_tag_load(i_tag_load),
  .i_tag_value(i_tag_value),
  .o_accept(o_accept),
  .o_discard(o_discard),
  .o_dequeue_start(o_dequeue_start),
  .o_push_refused(o_push_refused),
  .o_privileged(o_privileged),
  .o_alert_tag(o_alert_tag)
);
`default_nettype wire

// ### verif/alert_master_model.sv
// master model sending alert replies
`default_nettype none
module alert_master_model (
  // clock in, message bytes out
  input wire logic i_clk,
  output logic o_valid,
  output logic o_first,
  output logic o_last,
  output logic [7:0] o_byte
);
  timeunit 1ns / 1ps;
  initial {o_valid, o_first, o_last, o_byte} = '0;
  // whole reply, tag and code copied
  task automatic send(logic [7:0] code, logic [7:0] rc, logic [15:0] t,
    logic [23:0] c);
    logic [55:0] b = {code, rc, t, c};
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      {o_valid, o_first, o_last} <= {1'b1, i == 0, i == 6};
      o_byte <= b[55 - 8 * i -: 8];
    end
    @(posedge i_clk);
    {o_valid, o_first, o_last} <= '0;
    o_byte <= ~o_byte; // released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// bench top for the alert reply acceptor
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  logic i_clk = '0, i_rst_n = '0, i_alert_push = '0, i_tag_load = '0;
  logic [7:0] i_alert_type = '0, i_alert_subclass = '0, i_alert_info = '0;
  logic [15:0] i_tag_value = '0, o_alert_tag, tag;
  logic i_msg_valid, i_msg_first, i_msg_last, o_accept, o_discard;
  logic o_dequeue_start, o_push_refused, o_privileged, o_pending, o_queue_full;
  logic [7:0] i_msg_byte, o_return_code;
  logic [23:0] q[$];
  int error_cnt, samples_checked;
  // clock, master, block, watchdog
  always #10 i_clk = ~i_clk;
  alert_master_model m (.i_clk(i_clk), .o_valid(i_msg_valid),
    .o_first(i_msg_first), .o_last(i_msg_last), .o_byte(i_msg_byte));
  alert_reply_acceptor dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_msg_valid(i_msg_valid),
    .i_msg_first(i_msg_first),
    .i_msg_last(i_msg_last),
    .i_msg_byte(i_msg_byte),
    .i_alert_push(i_alert_push),
    .i_alert_type(i_alert_type),
    .i_alert_subclass(i_alert_subclass),
    .i_alert_info(i_alert_info),
    .i_tag_load(i_tag_load),
    .i_tag_value(i_tag_value),
    .o_accept(o_accept),
    .o_discard(o_discard),
    .o_dequeue_start(o_dequeue_start),
    .o_return_code(o_return_code),
    .o_push_refused(o_push_refused),
    .o_privileged(o_privileged),
    .o_pending(o_pending),
    .o_queue_full(o_queue_full),
    .o_alert_tag(o_alert_tag)
  );
  initial #90000 report_and_stop(1);
  // compare and count
  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    samples_checked++;
    error_cnt += (s !== e);
    if (s !== e) $display("[ERR] %s exp %h got %h", n, e, s);
  endtask
  task automatic report_and_stop(int e = 0);
    error_cnt += e;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // queue one alert
  task automatic push(logic [23:0] c, logic e);
    i_alert_push <= 1'b1;
    {i_alert_type, i_alert_subclass, i_alert_info} <= c;
    @(posedge i_clk);
    i_alert_push <= 1'b0;
    // refusal pulse stands for the cycle after the push edge
    @(negedge i_clk);
    chk("refused", o_push_refused, e);
    if (!e) q.push_back(c);
    @(posedge i_clk);
  endtask
  // one reply against the queue model; other codes are dropped silently
  task automatic reply(logic [7:0] rc, logic [15:0] t, logic [23:0] c,
    logic [7:0] code = alert_reply_pkg::REPLY_CODE);
    logic coded = code == alert_reply_pkg::REPLY_CODE;
    logic ok = coded && q.size() > 0 && t == tag && c == q[0];
    m.send(code, rc, t, c);
    repeat (3) begin
      @(posedge i_clk);
      #1 if (o_accept | o_discard) break;
    end
    chk("res", {o_accept, o_discard, o_dequeue_start},
      {ok, coded && !ok, ok});
    if (ok) chk("rc", o_return_code, rc);
    if (ok) void'(q.pop_front());
  endtask
  // main sequence
  initial begin
    void'($urandom(32'he10eccd3));
    tag = 16'($urandom); // port tag
    repeat (3) @(posedge i_clk);
    {i_rst_n, i_tag_load, i_tag_value} <= {2'b11, tag};
    @(posedge i_clk);
    i_tag_load <= 1'b0;
    push({8'($urandom_range(255, 188)), 16'($urandom)}, 1'b1);
    push({8'($urandom_range(25, 16)), 16'($urandom)}, 1'b0);
    chk("priv", o_privileged, 1'b1);
    repeat (3) push({8'($urandom_range(187, 26)), 16'($urandom)}, 1'b0);
    push(24'h1a0000, 1'b1); // full queue refuses
    chk("full", o_queue_full,
      q.size() == alert_reply_pkg::QUEUE_DEPTH);
    chk("pend", o_pending, q.size() != 0);
    reply(8'h00, tag, q[1]);
    reply(8'h00, ~tag, q[0]);
    reply(8'h00, tag, q[0] ^ 24'h000001);
    reply(8'h00, tag, q[0], 8'h02);
    while (q.size() > 0) reply({8{1'($urandom)}}, tag, q[0]);
    chk("tag", o_alert_tag, tag);
    reply(8'h00, tag, 24'h1a0000); // empty queue
    chk("pend", o_pending, q.size() != 0);
    chk("full", o_queue_full, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
